// ### core/nfh_consts.svh
// Command codes, identifier offsets and bus timing for the flash host controller.
// Assumes inclusion by the host controller module and the testbench.
`ifndef NFH_CONSTS_SVH
`define NFH_CONSTS_SVH
`define NFH_CMD_UNLOCK1 8'hAA
`define NFH_CMD_UNLOCK2 8'h55
`define NFH_CMD_IDENT 8'h90
`define NFH_CMD_PROG 8'hA0
`define NFH_CMD_ERASE_SETUP 8'h80
`define NFH_CMD_CHIP_ERASE 8'h10
`define NFH_CMD_SECTOR_ERASE 8'h30
`define NFH_CMD_SUSPEND 8'hB0
`define NFH_CMD_RESUME 8'h30
`define NFH_CMD_RESET 8'hF0
`define NFH_CMD_QUERY 8'h98
`define NFH_UNLOCK_ADDR 21'h000AAA
`define NFH_ID_MFR_ADDR 21'h000000
`define NFH_ID_DEV_ADDR 21'h000001
`define NFH_PROT_OFFSET 16'h0002
`define NFH_SECT_LSB 16
`define NFH_PROT_YES 8'h01
`define NFH_CYCLE_NS 5
`define NFH_ACCESS_NS 70
`define NFH_WRPULSE_NS 35
`define NFH_RESET_NS 500
`define NFH_OP_ARRAY_READ 4'h0
`define NFH_OP_IDENT 4'h1
`define NFH_OP_PROT_VERIFY 4'h2
`define NFH_OP_PROGRAM 4'h3
`define NFH_OP_CHIP_ERASE 4'h4
`define NFH_OP_SECTOR_ERASE 4'h5
`define NFH_OP_SUSPEND 4'h6
`define NFH_OP_RESUME 4'h7
`define NFH_OP_RESET 4'h8
`define NFH_OP_QUERY 4'h9
`define NFH_OP_READ 4'hA
`define NFH_OP_HW_RESET 4'hB
`endif

// ### core/nfh_flash_host.sv
// Host controller that drives a byte-wide asynchronous NOR flash through its pins.
// Assumes one request at a time from same-clock logic; flash data pins sampled via two flops.
`timescale 1ns/10ps
`include "nfh_consts.svh"

module nfh_flash_host
  import nfh_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic [3:0] reqOp,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  input wire logic tempUnprotect,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic rspRefused,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [DATA_W-1:0] flashDqIn,
  output logic flashCe_n,
  output logic flashOe_n,
  output logic flashWe_n,
  output logic flashReset_n,
  output logic flashResetElevated
);
  localparam int CYC_NS = `NFH_CYCLE_NS;
  localparam int ACC_CYC = (`NFH_ACCESS_NS + CYC_NS - 1) / CYC_NS + 3;
  localparam int WP_CYC = (`NFH_WRPULSE_NS + CYC_NS - 1) / CYC_NS;
  localparam int RST_CYC = (`NFH_RESET_NS + CYC_NS - 1) / CYC_NS;
  localparam int MAXW = 6;

  nfh_state_t state_r;
  nfh_mode_t mode_r;
  logic [7:0] cnt_r;
  logic [2:0] idx_r;
  logic [2:0] len_r;
  logic [ADDR_W-1:0] seqAddr_r [MAXW];
  logic [DATA_W-1:0] seqData_r [MAXW];
  logic isRead_r;
  logic [DATA_W-1:0] dqMeta_r;
  logic [DATA_W-1:0] dqSync_r;
  logic accept;
  logic legal;
  logic erSusp_r;
  logic [ADDR_W-1:0] sectBase;

  always_comb begin
    sectBase = '0;
    sectBase[ADDR_W-1:`NFH_SECT_LSB] = reqAddr[ADDR_W-1:`NFH_SECT_LSB];
  end

  // Suspend refused outside a running sector erase, resume refused unless an erase is suspended
  always_comb begin
    unique case (reqOp)
      `NFH_OP_SUSPEND: legal = (mode_r == NFH_MODE_ERASING);
      `NFH_OP_RESUME: legal = erSusp_r;
      `NFH_OP_ARRAY_READ, `NFH_OP_IDENT, `NFH_OP_PROT_VERIFY, `NFH_OP_PROGRAM, `NFH_OP_CHIP_ERASE,
      `NFH_OP_SECTOR_ERASE, `NFH_OP_RESET, `NFH_OP_QUERY, `NFH_OP_READ, `NFH_OP_HW_RESET: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  assign accept = reqValid && reqReady;

  // Synchroniser for flash data pins
  always_ff @(posedge ref_clk) begin
    dqMeta_r <= flashDqIn;
    dqSync_r <= dqMeta_r;
  end

  // Sequence builder: whole sequences only, addresses on unlocks are don't care
  always_ff @(posedge ref_clk) begin
    if (accept && legal) begin
      for (int i = 0; i < MAXW; i++) begin
        seqAddr_r[i] <= `NFH_UNLOCK_ADDR;
        seqData_r[i] <= '0;
      end
      seqData_r[0] <= `NFH_CMD_UNLOCK1;
      seqData_r[1] <= `NFH_CMD_UNLOCK2;
      seqData_r[3] <= `NFH_CMD_UNLOCK1;
      seqData_r[4] <= `NFH_CMD_UNLOCK2;
      unique case (reqOp)
        `NFH_OP_IDENT, `NFH_OP_PROT_VERIFY: begin
          seqData_r[2] <= `NFH_CMD_IDENT;
          seqAddr_r[3] <= (reqOp == `NFH_OP_IDENT) ? reqAddr : (sectBase | ADDR_W'(`NFH_PROT_OFFSET));
        end
        `NFH_OP_PROGRAM: begin
          seqData_r[2] <= `NFH_CMD_PROG;
          seqAddr_r[3] <= reqAddr;
          seqData_r[3] <= reqData;
        end
        `NFH_OP_CHIP_ERASE: begin
          seqData_r[2] <= `NFH_CMD_ERASE_SETUP;
          seqData_r[5] <= `NFH_CMD_CHIP_ERASE;
        end
        `NFH_OP_SECTOR_ERASE: begin
          seqData_r[2] <= `NFH_CMD_ERASE_SETUP;
          seqAddr_r[5] <= sectBase;
          seqData_r[5] <= `NFH_CMD_SECTOR_ERASE;
        end
        `NFH_OP_SUSPEND: seqData_r[0] <= `NFH_CMD_SUSPEND;
        `NFH_OP_RESUME: seqData_r[0] <= `NFH_CMD_RESUME;
        `NFH_OP_RESET, `NFH_OP_ARRAY_READ: seqData_r[0] <= `NFH_CMD_RESET;
        `NFH_OP_QUERY: begin
          seqData_r[0] <= `NFH_CMD_QUERY;
          seqAddr_r[0] <= reqAddr;
        end
        default: seqAddr_r[0] <= reqAddr;
      endcase
    end
  end

  // Write count and read flag per request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      len_r <= 3'h0;
      isRead_r <= 1'b0;
    end else if (accept && legal) begin
      isRead_r <= (reqOp == `NFH_OP_READ);
      unique case (reqOp)
        `NFH_OP_IDENT, `NFH_OP_PROGRAM: len_r <= 3'h3;
        `NFH_OP_PROT_VERIFY: len_r <= 3'h3;
        `NFH_OP_CHIP_ERASE, `NFH_OP_SECTOR_ERASE: len_r <= 3'h6;
        `NFH_OP_READ, `NFH_OP_HW_RESET: len_r <= 3'h0;
        default: len_r <= 3'h1;
      endcase
    end
  end

  // Program writes four cycles; identifier modes end with a read of cycle 3
  logic [2:0] wrLen;
  assign wrLen = (seqData_r[2] == `NFH_CMD_PROG && len_r == 3'h3) ? 3'h4 : len_r;

  // Bus sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= NFH_IDLE;
      cnt_r <= 8'h00;
      idx_r <= 3'h0;
      reqReady <= 1'b0;
    end else begin
      unique case (state_r)
        NFH_IDLE: begin
          reqReady <= 1'b1;
          idx_r <= 3'h0;
          if (accept) begin
            reqReady <= 1'b0;
            if (!legal) state_r <= NFH_DONE;
            else if (reqOp == `NFH_OP_HW_RESET) begin
              state_r <= NFH_RSTPULSE;
              cnt_r <= 8'(RST_CYC);
            end else if (reqOp == `NFH_OP_READ) begin
              state_r <= NFH_RPULSE;
              cnt_r <= 8'(ACC_CYC);
            end else begin
              state_r <= NFH_WSETUP;
              cnt_r <= 8'h01;
            end
          end
        end
        NFH_WSETUP: begin
          if (cnt_r == 8'h00) begin
            state_r <= NFH_WPULSE;
            cnt_r <= 8'(WP_CYC);
          end else cnt_r <= cnt_r - 8'h01;
        end
        NFH_WPULSE: begin
          if (cnt_r == 8'h00) begin
            idx_r <= idx_r + 3'h1;
            cnt_r <= 8'h01;
            if (idx_r + 3'h1 < wrLen) state_r <= NFH_WSETUP;
            else if (wrLen == 3'h3) begin
              state_r <= NFH_RPULSE;
              cnt_r <= 8'(ACC_CYC);
            end else state_r <= NFH_DONE;
          end else cnt_r <= cnt_r - 8'h01;
        end
        NFH_RPULSE, NFH_RSTPULSE: begin
          if (cnt_r == 8'h00) state_r <= NFH_DONE;
          else cnt_r <= cnt_r - 8'h01;
        end
        NFH_DONE: state_r <= NFH_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flashCe_n <= 1'b1;
      flashOe_n <= 1'b1;
      flashWe_n <= 1'b1;
      flashDqOe <= 1'b0;
      flashReset_n <= 1'b1;
      flashAddr <= '0;
      flashDqOut <= '0;
    end else begin
      flashReset_n <= !(state_r == NFH_RSTPULSE && cnt_r != 8'h00);
      flashCe_n <= !(state_r == NFH_WSETUP || state_r == NFH_WPULSE || state_r == NFH_RPULSE);
      flashWe_n <= !(state_r == NFH_WPULSE && cnt_r != 8'h00);
      flashOe_n <= !(state_r == NFH_RPULSE);
      flashDqOe <= (state_r == NFH_WSETUP || state_r == NFH_WPULSE);
      flashAddr <= seqAddr_r[idx_r];
      flashDqOut <= seqData_r[idx_r];
    end
  end

  // Elevated reset level is a separate drive request, not a logic high
  always_ff @(posedge ref_clk) begin
    if (rst) flashResetElevated <= 1'b0;
    else flashResetElevated <= tempUnprotect;
  end

  // Tracks flash mode to gate suspend; resume is gated by erSusp_r
  always_ff @(posedge ref_clk) begin
    if (rst) mode_r <= NFH_MODE_ARRAY;
    else if (accept && legal) begin
      unique case (reqOp)
        `NFH_OP_RESET, `NFH_OP_HW_RESET, `NFH_OP_CHIP_ERASE, `NFH_OP_PROGRAM: mode_r <= NFH_MODE_ARRAY;
        `NFH_OP_IDENT, `NFH_OP_PROT_VERIFY: mode_r <= NFH_MODE_IDENT;
        `NFH_OP_QUERY: mode_r <= NFH_MODE_QUERY;
        `NFH_OP_SECTOR_ERASE, `NFH_OP_RESUME: mode_r <= NFH_MODE_ERASING;
        `NFH_OP_SUSPEND, `NFH_OP_ARRAY_READ: mode_r <= NFH_MODE_ARRAY;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Suspend kept apart from mode so that resume stays legal after it
  always_ff @(posedge ref_clk) begin
    if (rst) erSusp_r <= 1'b0;
    else if (accept && legal && reqOp == `NFH_OP_SUSPEND) erSusp_r <= 1'b1;
    else if (accept && legal && reqOp inside {`NFH_OP_RESUME, `NFH_OP_RESET, `NFH_OP_ARRAY_READ,
      `NFH_OP_HW_RESET, `NFH_OP_CHIP_ERASE, `NFH_OP_SECTOR_ERASE}) erSusp_r <= 1'b0;
  end

  // Response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData <= '0;
      rspRefused <= 1'b0;
    end else begin
      rspValid <= (state_r == NFH_DONE);
      rspRefused <= (state_r == NFH_IDLE && accept && !legal) ? 1'b1 : (state_r == NFH_DONE ? rspRefused : 1'b0);
      if (state_r == NFH_RPULSE && cnt_r == 8'h00) rspData <= dqSync_r;
    end
  end

  AST_WE_OE_EXCL: assert property (@(posedge ref_clk) disable iff (rst) !(!flashWe_n && !flashOe_n))
    else $error("write and output enable low together");
  AST_OE_NO_DRIVE: assert property (@(posedge ref_clk) disable iff (rst) !flashOe_n |-> !flashDqOe)
    else $error("host drives data while flash outputs");
  AST_WE_NEEDS_CE: assert property (@(posedge ref_clk) disable iff (rst) !flashWe_n |-> !flashCe_n)
    else $error("write pulse without chip select");
  AST_SUSPEND_ERASE: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && (reqOp == `NFH_OP_SUSPEND) && mode_r != NFH_MODE_ERASING) |=> (state_r == NFH_DONE))
    else $error("suspend issued outside sector erase");
  AST_RESET_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(flashReset_n) |-> !flashReset_n [*8])
    else $error("reset pulse too short");
  AST_BAD_OP: assert property (@(posedge ref_clk) disable iff (rst) (accept && !legal) |=> ##1 rspValid)
    else $error("refused request not answered");
  AST_SECT_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && reqOp == `NFH_OP_SECTOR_ERASE) |=> seqAddr_r[5][`NFH_SECT_LSB-1:0] == '0)
    else $error("sector erase address not sector aligned");
  AST_WE_IDLE_CE: assert property (@(posedge ref_clk) disable iff (rst) (state_r == NFH_IDLE) |=> flashCe_n)
    else $error("chip select held in idle");
endmodule : nfh_flash_host

// ### core/nfh_pkg.sv
// Types of the flash host controller.
// Assumes nfh_consts.svh alongside.
package nfh_pkg;
  typedef enum logic [5:0] {
    NFH_IDLE = 6'h01,
    NFH_WSETUP = 6'h02,
    NFH_WPULSE = 6'h04,
    NFH_RPULSE = 6'h08,
    NFH_RSTPULSE = 6'h10,
    NFH_DONE = 6'h20
  } nfh_state_t;
  typedef enum logic [1:0] {
    NFH_MODE_ARRAY = 2'h0,
    NFH_MODE_IDENT = 2'h1,
    NFH_MODE_QUERY = 2'h2,
    NFH_MODE_ERASING = 2'h3
  } nfh_mode_t;
endpackage : nfh_pkg

// ### tb/nfh_flash_model.sv
// Behavioural byte-wide flash: command decoder, identifier, query and array.
// Assumes its pins are driven by the host controller; counts bus and sequence faults.
`timescale 1ns/10ps
module nfh_flash_model #(
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] QT [13] = '{13{8'h00}}
) (
  input wire logic [20:0] flashAddr,
  input wire logic [7:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashCe_n,
  input wire logic flashOe_n,
  input wire logic flashWe_n,
  input wire logic flashReset_n,
  input wire logic flashResetElevated,
  output logic [7:0] flashDqIn
);
  logic [7:0] mem [int];
  logic [31:0] erasedSec = '0;
  logic [2:0] st = '0;
  logic [1:0] mode = '0; // 0 array, 1 identifier, 2 query
  logic [1:0] ers = '0; // 0 idle, 1 erasing, 2 suspended
  logic [20:0] aLat = '0;
  int badSeq = 0, badBus = 0, wcnt = 0;
  realtime tLow = 0, minLow = 1e9;

  function automatic logic [7:0] rdv(input logic [20:0] x);
    if (mode == 2'd1)
      return x[1:0] == 2'd0 ? MFR_ID : x[1:0] == 2'd1 ? DEV_ID : x[1:0] == 2'd2 ? {7'h0, x[16]} : 8'h00;
    if (mode == 2'd2)
      return (x[7:0] >= 8'h40 && x[7:0] <= 8'h4C) ? QT[x[7:0]-8'h40] : 8'h00;
    if (mem.exists(x))
      return mem[x];
    return erasedSec[x[20:16]] ? 8'hFF : x[7:0] ^ x[15:8];
  endfunction : rdv

  task automatic step(input logic [7:0] d);
    logic ok;
    logic [4:0] s;
    ok = 1'b1;
    s = aLat[20:16];
    wcnt++;
    case (st)
      3'd0: if (d == 8'hAA) st = 3'd1;
        else if (d == 8'hF0) begin mode = 2'd0; ers = 2'd0; end
        else if (d == 8'h98) mode = 2'd2;
        else if (d == 8'hB0 && ers == 2'd1) ers = 2'd2;
        else if (d == 8'h30 && ers == 2'd2) ers = 2'd1;
        else ok = 1'b0;
      3'd1: if (d == 8'h55) st = 3'd2; else ok = 1'b0;
      3'd2: if (d == 8'h90) begin mode = 2'd1; st = 3'd0; end
        else if (d == 8'hA0) st = 3'd3;
        else if (d == 8'h80) st = 3'd4;
        else ok = 1'b0;
      3'd3: begin
        if (!s[0] || flashResetElevated === 1'b1) mem[aLat] = d;
        st = 3'd0;
      end
      3'd4: if (d == 8'hAA) st = 3'd5; else ok = 1'b0;
      3'd5: if (d == 8'h55) st = 3'd6; else ok = 1'b0;
      default: begin
        st = 3'd0;
        if (d == 8'h10) begin mem.delete(); erasedSec = '1; end
        else if (d == 8'h30) begin
          erasedSec[s] = 1'b1;
          ers = 2'd1;
          foreach (mem[k]) if (k[20:16] == s) mem[k] = 8'hFF;
        end else ok = 1'b0;
      end
    endcase
    if (!ok) begin st = 3'd0; mode = 2'd0; badSeq++; end
  endtask : step

  always @(negedge flashWe_n) aLat = flashAddr;
  always @(posedge flashWe_n) begin
    if (!flashCe_n && flashReset_n) begin
      if (!flashOe_n) badBus++;
      step(flashDqOut);
    end
  end
  // Checked once the host's pins of this edge have all settled
  always @(negedge flashOe_n) begin
    #1;
    if (!flashWe_n || flashDqOe) badBus++;
  end
  always @(negedge flashReset_n) tLow = $realtime;
  always @(posedge flashReset_n) begin
    // Ignores any pulse around power-up
    if (tLow > 100 && $realtime - tLow < minLow) minLow = $realtime - tLow;
    st = 3'd0;
    mode = 2'd0;
    ers = 2'd0;
  end
  // Unselected bus shows inverted data, never a stale value
  always @(flashAddr, mode, wcnt, flashCe_n, flashOe_n, flashReset_n)
    flashDqIn = (!flashCe_n && !flashOe_n && flashReset_n) ? rdv(flashAddr) : ~rdv(flashAddr);
endmodule : nfh_flash_model

// ### tb/tb.sv
// Self-checking bench for the flash host controller against a behavioural flash.
// Assumes nfh_pkg, the controller and the flash model compiled first.
`timescale 1ns/10ps
`include "nfh_consts.svh"
module tb;
  localparam logic [7:0] QT [13] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01, 8'h02, 8'h01, 8'h01, 8'h04,
    8'h00, 8'h00, 8'h00};
  logic ref_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, tempUnprotect = 1'b0;
  logic [3:0] reqOp = 4'h0;
  logic [20:0] reqAddr = '0, flashAddr, a;
  logic [7:0] reqData = '0, rspData, flashDqOut, flashDqIn, got, d;
  logic reqReady, rspValid, rspRefused, flashDqOe, flashCe_n, flashOe_n, flashWe_n, flashReset_n;
  logic flashResetElevated, refused;
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'hCEA8;

  nfh_flash_host i_dut (.ref_clk, .rst, .reqValid, .reqOp, .reqAddr, .reqData, .tempUnprotect, .reqReady,
    .rspValid, .rspData, .rspRefused, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashCe_n, .flashOe_n,
    .flashWe_n, .flashReset_n, .flashResetElevated);
  nfh_flash_model #(.MFR_ID(8'h5A), .DEV_ID(8'hA5), .QT(QT)) i_flash (.flashAddr, .flashDqOut, .flashDqOe,
    .flashCe_n, .flashOe_n, .flashWe_n, .flashReset_n, .flashResetElevated, .flashDqIn);

  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin n_mismatch++; $display("BAD %0t data %h exp %h", $time, g, e); end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin n_mismatch++; $display("BAD %0t flag %b exp %b", $time, g, e); end
  endtask : chk1

  task automatic req(input logic [3:0] op, input logic [20:0] ad, input logic [7:0] dt);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqAddr <= ad;
    reqData <= dt;
    do @(posedge ref_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do @(posedge ref_clk); while (rspValid !== 1'b1);
    got = rspData;
    refused = rspRefused;
  endtask : req

  // Hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin n_mismatch++; stop_test(); end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk1(flashCe_n & flashWe_n & flashOe_n & ~flashDqOe, 1'b1);
    req(4'h6, 21'h0, 8'h00);
    chk1(refused, 1'b1);
    req(4'h7, 21'h0, 8'h00);
    chk1(refused, 1'b1);
    req(4'h1, 21'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      req(4'hA, {a[20:2], 1'b0, i[0]}, 8'h00);
      chk8(got, i[0] ? 8'hA5 : 8'h5A);
      a[16] = i[1];
      req(4'h2, a, 8'h00);
      chk8(got, {7'h0, a[16]});
    end
    req(4'h8, 21'h0, 8'h00);
    a = $random(seed);
    req(4'hA, a, 8'h00);
    chk8(got, a[7:0] ^ a[15:8]);
    req(4'h9, a, 8'h00);
    for (int i = 0; i < 13; i++) begin
      req(4'hA, {a[20:8], 8'h40 + i[7:0]}, 8'h00);
      chk8(got, QT[i]);
    end
    req(4'h0, a, 8'h00);
    req(4'hA, a, 8'h00);
    chk8(got, a[7:0] ^ a[15:8]);
    req(4'h8, 21'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      d = $random(seed);
      a[16] = i[0];
      tempUnprotect <= i[1];
      req(4'h3, a, d);
      chk1(flashResetElevated, i[1]);
      req(4'hA, a, 8'h00);
      chk8(got, (a[16] && !i[1]) ? a[7:0] ^ a[15:8] : d);
    end
    req(4'h5, a, 8'h00);
    req(4'hA, a, 8'h00);
    chk8(got, 8'hFF);
    req(4'h6, 21'h0, 8'h00);
    chk1(refused, 1'b0);
    req(4'h6, 21'h0, 8'h00);
    chk1(refused, 1'b1);
    req(4'h7, 21'h0, 8'h00);
    chk1(refused, 1'b0);
    req(4'h8, 21'h0, 8'h00);
    req(4'h4, 21'h0, 8'h00);
    req(4'hA, {a[20:17], ~a[16], a[15:0]}, 8'h00);
    chk8(got, 8'hFF);
    req(4'h6, 21'h0, 8'h00);
    chk1(refused, 1'b1);
    req(4'h1, 21'h0, 8'h00);
    req(4'hB, 21'h0, 8'h00);
    req(4'hA, 21'h0, 8'h00);
    chk8(got, 8'hFF);
    chk1(i_flash.minLow >= `NFH_RESET_NS && i_flash.minLow < 1e9, 1'b1);
    chk1(i_flash.badSeq == 0, 1'b1);
    chk1(i_flash.badBus == 0, 1'b1);
    stop_test();
  end
endmodule : tb
